// >>> hw/lem_addr_form.sv
/*
 * lem_addr_form: real-style base and linear address forming for emulation mode.
 * assumes: driven from lem_mode_ctrl over lem_seg_if; pure combinational path.
 */
`timescale 1ns/1ns
`default_nettype none
module lem_addr_form
    import lem_pkg::*;
(
    lem_seg_if.addr sif
);
    logic [LIN20_W:0] sum21;
    // ============================================================
    // address forming
    always_comb
    begin
        // segment times sixteen plus offset; carry kept so top reaches 10FFEF
        sum21 = {1'b0, sif.segValue, {SEG_SHIFT{1'b0}}} + {5'h00, sif.offset};
        sif.useRealStyle = sif.emuMode;
        sif.linAddr = {{(LIN_W-LIN20_W-1){1'b0}}, sum21};
    end
endmodule : lem_addr_form
`default_nettype wire

// >>> hw/lem_mode_ctrl.sv
/*
 * lem_mode_ctrl: holds the emulation mode flag and steers decode, privilege,
 * segment loading and page checks from it.
 * assumes: the core's sequencer pulses the event inputs for one cycle each,
 * and presents the loaded flags image on the same cycle as the event.
 */
`timescale 1ns/1ns
`default_nettype none
module lem_mode_ctrl
    import lem_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic initReq,
    input wire logic taskSwitch,
    input wire logic taskImage32,
    input wire logic [FLAGS_W-1:0] taskFlagsImage,
    input wire logic interruptReturn,
    input wire logic [FLAGS_W-1:0] stackFlagsImage,
    input wire logic flagsWrite,
    input wire logic [FLAGS_W-1:0] flagsWriteData,
    input wire logic [1:0] protPrivLevel,
    input wire logic [1:0] ioPrivLevel,
    input wire logic [SEG_W-1:0] segImage,
    input wire logic [SEG_W-1:0] addrOffset,
    input wire logic pageUserBit,
    input wire logic pageAccess,
    input wire logic [1:0] insnClass,
    output logic [FLAGS_W-1:0] flagsRegister,
    output logic emulationModeFlag,
    output logic [1:0] currentPrivilegeLevel,
    output logic segLoadValid,
    output logic [2:0] segLoadIndex,
    output logic segRealStyle,
    output logic [LIN_W-1:0] segBase,
    output logic [LIN_W-1:0] linearAddr,
    output logic insnUnsupported,
    output logic insnIoplFault,
    output logic pageDeny
);
    lem_seg_if sif();
    lem_addr_form u_addr (.sif(sif));

    lem_state_t state_r, state_nxt;
    logic [FLAGS_W-1:0] flags_r, flags_nxt;
    logic [2:0] segIdx_r, segIdx_nxt;
    logic [SEG_W-1:0] segVal_r, segVal_nxt;
    logic [LIN_W-1:0] base_r, base_nxt;
    logic [LIN_W-1:0] lin_r, lin_nxt;
    logic segValid_r, segValid_nxt;
    logic realStyle_r, realStyle_nxt;
    logic [2:0] loadIdx_r, loadIdx_nxt;
    logic [FLAGS_W-1:0] loadImg;
    logic emu;

    assign emu = flags_r[EMU_FLAG_BIT];
    // ============================================================
    // flag and task switch sequence
    always_comb
    begin
        state_nxt = state_r;
        flags_nxt = flags_r;
        segIdx_nxt = segIdx_r;
        segVal_nxt = segImage;
        segValid_nxt = 1'b0;
        loadImg = taskFlagsImage;
        if (!taskImage32)
        begin
            // upper word absent in the small image format
            loadImg[FLAGS_W-1:SEG_W] = '0;
        end
        unique case (state_r)
            LEM_IDLE:
            begin
                if (taskSwitch)
                begin
                    // flag first, then segments, so the new mode governs them
                    flags_nxt = loadImg;
                    state_nxt = LEM_FLAGS;
                end
                else if (interruptReturn)
                begin
                    flags_nxt = stackFlagsImage;
                end
                else if (flagsWrite)
                begin
                    flags_nxt = flagsWriteData;
                    flags_nxt[EMU_FLAG_BIT] = flags_r[EMU_FLAG_BIT];
                end
            end
            LEM_FLAGS:
            begin
                segIdx_nxt = 3'h0;
                state_nxt = LEM_SEGS;
            end
            LEM_SEGS:
            begin
                segValid_nxt = 1'b1;
                if (segIdx_r == 3'(NUM_SEGS - 1))
                begin
                    state_nxt = LEM_IDLE;
                end
                else
                begin
                    segIdx_nxt = segIdx_r + 3'h1;
                end
            end
        endcase
        if (initReq)
        begin
            // init drops straight back to real-address operation
            flags_nxt = FLAGS_RESET;
            state_nxt = LEM_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= LEM_IDLE;
            flags_r <= FLAGS_RESET;
            segIdx_r <= 3'h0;
        end
        else
        begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            segIdx_r <= segIdx_nxt;
        end
    end
    // ============================================================
    // segment and address outputs
    assign sif.emuMode = emu;
    assign sif.segValue = segVal_r;
    assign sif.offset = addrOffset;
    always_comb
    begin
        realStyle_nxt = sif.useRealStyle;
        // the counter has moved on when the pulse shows, so report its last value
        loadIdx_nxt = segIdx_r;
        // base is the address at offset zero; only valid in real style
        base_nxt = emu ? {12'h000, segImage, 4'h0} : '0;
        lin_nxt = sif.linAddr;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            segVal_r <= '0;
            segValid_r <= 1'b0;
            loadIdx_r <= 3'h0;
            realStyle_r <= 1'b0;
            base_r <= '0;
            lin_r <= '0;
        end
        else
        begin
            segVal_r <= segVal_nxt;
            segValid_r <= segValid_nxt;
            loadIdx_r <= loadIdx_nxt;
            realStyle_r <= realStyle_nxt;
            base_r <= base_nxt;
            lin_r <= lin_nxt;
        end
    end
    // ============================================================
    // decode, privilege and page checks
    always_comb
    begin
        currentPrivilegeLevel = emu ? EMU_PRIV_LEVEL : protPrivLevel;
        // class 1: not available in emulation; class 2: privilege-sensitive
        insnUnsupported = emu && (insnClass == 2'h1);
        insnIoplFault = emu && (insnClass == 2'h2) && (ioPrivLevel != EMU_PRIV_LEVEL);
        pageDeny = pageAccess && !pageUserBit && (currentPrivilegeLevel == EMU_PRIV_LEVEL);
    end

    assign flagsRegister = flags_r;
    assign emulationModeFlag = emu;
    assign segLoadValid = segValid_r;
    assign segLoadIndex = loadIdx_r;
    assign segRealStyle = realStyle_r;
    assign segBase = base_r;
    assign linearAddr = lin_r;
    // ============================================================
    // checks
    a_direct_write_keeps: assert property (@(posedge clk) disable iff (!resetn)
        flagsWrite && !taskSwitch && !interruptReturn && !initReq && state_r == LEM_IDLE
        |=> $stable(emulationModeFlag))
        else $error("flags write changed emulation flag");
    a_small_image_clears: assert property (@(posedge clk) disable iff (!resetn)
        taskSwitch && !taskImage32 && !initReq && state_r == LEM_IDLE
        |=> !emulationModeFlag)
        else $error("small image left flag set");
    a_switch_enters: assert property (@(posedge clk) disable iff (!resetn)
        taskSwitch && taskImage32 && taskFlagsImage[EMU_FLAG_BIT] && !initReq
        && state_r == LEM_IDLE |=> emulationModeFlag)
        else $error("task switch did not enter mode");
    a_return_enters: assert property (@(posedge clk) disable iff (!resetn)
        interruptReturn && !taskSwitch && stackFlagsImage[EMU_FLAG_BIT] && !initReq
        && state_r == LEM_IDLE |=> emulationModeFlag)
        else $error("return did not enter mode");
    a_only_legal_set: assert property (@(posedge clk) disable iff (!resetn)
        $rose(emulationModeFlag) |-> $past(taskSwitch) || $past(interruptReturn))
        else $error("flag set without switch or return");
    // an init in the cycle after the switch aborts the sequence, so it is excluded
    a_flag_before_segs: assert property (@(posedge clk) disable iff (!resetn)
        (taskSwitch && state_r == LEM_IDLE && !initReq) ##1 !initReq
        |-> !segLoadValid ##2 segLoadValid)
        else $error("segments loaded before flag");
    a_first_seg_index: assert property (@(posedge clk) disable iff (!resetn)
        (taskSwitch && state_r == LEM_IDLE && !initReq) ##1 !initReq
        |-> ##2 (segLoadValid && segLoadIndex == 3'h0))
        else $error("first segment load not index zero");
    a_priv_fixed: assert property (@(posedge clk) disable iff (!resetn)
        emulationModeFlag |-> currentPrivilegeLevel == 2'h3)
        else $error("privilege not 3");
    a_init_leaves: assert property (@(posedge clk) disable iff (!resetn)
        initReq |=> !emulationModeFlag && state_r == LEM_IDLE)
        else $error("init kept mode");
    a_addr_bound: assert property (@(posedge clk) disable iff (!resetn)
        $past(emulationModeFlag) |-> linearAddr <= 32'h0010_FFEF)
        else $error("address beyond bound");
    a_super_denied: assert property (@(posedge clk) disable iff (!resetn)
        emulationModeFlag && pageAccess && !pageUserBit |-> pageDeny)
        else $error("supervisor page allowed");
endmodule : lem_mode_ctrl
`default_nettype wire

// >>> hw/lem_pkg.sv
/*
 * lem_pkg: constants and types shared by the emulation-mode entry logic.
 * assumes: included before the carrier interface and the design modules.
 */
package lem_pkg;
    // ============================================================
    // flag positions and widths
    localparam int FLAGS_W = 32;
    localparam int EMU_FLAG_BIT = 17;
    localparam int NESTED_TASK_BIT = 14;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic FLAG_EMU_RESET = 1'b0;
    // ============================================================
    // privilege and address figures
    localparam logic [1:0] EMU_PRIV_LEVEL = 2'h3;
    localparam int SEG_W = 16;
    localparam int LIN20_W = 20;
    localparam int LIN_W = 32;
    localparam int SEG_SHIFT = 4;
    localparam logic [LIN_W-1:0] EMU_LIN_LIMIT = 32'h0010_FFEF;
    localparam int NUM_SEGS = 6;
    // ============================================================
    // task switch sequence
    typedef enum logic [1:0] {LEM_IDLE, LEM_FLAGS, LEM_SEGS} lem_state_t;
endpackage : lem_pkg

// >>> hw/lem_seg_if.sv
/*
 * lem_seg_if: carries one segment load between the mode logic and the address former.
 * assumes: a single clock domain; combinational lookups only.
 */
`timescale 1ns/1ns
`default_nettype none
interface lem_seg_if;
    import lem_pkg::*;
    logic emuMode;
    logic [SEG_W-1:0] segValue;
    logic [SEG_W-1:0] offset;
    logic [LIN_W-1:0] linAddr;
    logic useRealStyle;
    modport ctrl (output emuMode, output segValue, output offset, input linAddr,
        input useRealStyle);
    modport addr (input emuMode, input segValue, input offset, output linAddr,
        output useRealStyle);
endinterface : lem_seg_if
`default_nettype wire

// >>> testbench/legacy_emulation_mode_entry_tb.sv
/*
 * legacy_emulation_mode_entry_tb: self-checking bench for lem_mode_ctrl.
 * assumes: lem_pkg and lem_seg_if compiled first; one 25 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module legacy_emulation_mode_entry_tb
    import lem_pkg::*;
;
    // ============================================================
    // stimulus and observed signals
    logic clk, resetn, initReq, taskSwitch, taskImage32, interruptReturn, flagsWrite;
    logic [FLAGS_W-1:0] taskFlagsImage, stackFlagsImage, flagsWriteData, flagsRegister;
    logic [1:0] protPrivLevel, ioPrivLevel, insnClass, currentPrivilegeLevel;
    logic [SEG_W-1:0] segImage, addrOffset;
    logic pageUserBit, pageAccess, emulationModeFlag, segLoadValid, segRealStyle;
    logic insnUnsupported, insnIoplFault, pageDeny;
    logic [2:0] segLoadIndex;
    logic [LIN_W-1:0] segBase, linearAddr;
    int nMismatch = 0;
    int checksDone = 0;

    lem_mode_ctrl lem_mode_ctrl_inst (.clk(clk), .resetn(resetn), .initReq(initReq),
        .taskSwitch(taskSwitch), .taskImage32(taskImage32), .taskFlagsImage(taskFlagsImage),
        .interruptReturn(interruptReturn), .stackFlagsImage(stackFlagsImage),
        .flagsWrite(flagsWrite), .flagsWriteData(flagsWriteData),
        .protPrivLevel(protPrivLevel), .ioPrivLevel(ioPrivLevel), .segImage(segImage),
        .addrOffset(addrOffset), .pageUserBit(pageUserBit), .pageAccess(pageAccess),
        .insnClass(insnClass), .flagsRegister(flagsRegister),
        .emulationModeFlag(emulationModeFlag), .currentPrivilegeLevel(currentPrivilegeLevel),
        .segLoadValid(segLoadValid), .segLoadIndex(segLoadIndex), .segRealStyle(segRealStyle),
        .segBase(segBase), .linearAddr(linearAddr), .insnUnsupported(insnUnsupported),
        .insnIoplFault(insnIoplFault), .pageDeny(pageDeny));

    // ============================================================
    // shared tasks
    task automatic conclude;
        if (nMismatch == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle event; returns just after the edge that samples it
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: taskSwitch <= 1'b1;
            1: interruptReturn <= 1'b1;
            2: flagsWrite <= 1'b1;
            default: initReq <= 1'b1;
        endcase
        @(posedge clk);
        taskSwitch <= 1'b0;
        interruptReturn <= 1'b0;
        flagsWrite <= 1'b0;
        initReq <= 1'b0;
        #1;
    endtask : pulse

    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle

    // six segment loads, in order, each seeing the already updated flag
    task automatic seqCheck(input logic style);
        int n;
        n = 0;
        repeat (14)
        begin
            settle();
            if (segLoadValid === 1'b1)
            begin
                chk("segLoadIndex", n, segLoadIndex);
                chk("segRealStyle", style, segRealStyle);
                // segment value FFFF times sixteen in real style, zero otherwise
                chk("segBase", style ? 32'h000F_FFF0 : 32'h0000_0000, segBase);
                n++;
            end
        end
        chk("segLoadCount", 6, n);
    endtask : seqCheck

    // ============================================================
    // scenarios
    task automatic scnDirectWrite;
        @(posedge clk);
        flagsWriteData <= 32'h0002_08D7;
        pulse(2);
        settle();
        chk("flagsRegister", 32'h0000_08D7, flagsRegister);
        chk("emulationModeFlag", 0, emulationModeFlag);
        @(posedge clk);
        insnClass <= 2'h1;
        #1;
        chk("insnUnsupported", 0, insnUnsupported);
    endtask : scnDirectWrite

    task automatic scnEnterByTask;
        @(posedge clk);
        taskFlagsImage <= 32'h0002_0202;
        taskImage32 <= 1'b1;
        pulse(0);
        seqCheck(1'b1);
        chk("flagsRegister", 32'h0002_0202, flagsRegister);
        chk("currentPrivilegeLevel", 3, currentPrivilegeLevel);
        chk("linearAddr", 32'h0010_FFEF, linearAddr);
        @(posedge clk);
        flagsWriteData <= 32'h0000_0046;
        pulse(2);
        settle();
        chk("flagsRegister", 32'h0002_0046, flagsRegister);
        chk("emulationModeFlag", 1, emulationModeFlag);
    endtask : scnEnterByTask

    task automatic scnDecodeAndPages;
        @(posedge clk);
        insnClass <= 2'h1;
        #1;
        chk("insnUnsupported", 1, insnUnsupported);
        @(posedge clk);
        insnClass <= 2'h2;
        ioPrivLevel <= 2'h1;
        #1;
        chk("insnIoplFault", 1, insnIoplFault);
        @(posedge clk);
        ioPrivLevel <= 2'h3;
        pageAccess <= 1'b1;
        #1;
        chk("insnIoplFault", 0, insnIoplFault);
        chk("pageDeny", 1, pageDeny);
        @(posedge clk);
        pageUserBit <= 1'b1;
        #1;
        chk("pageDeny", 0, pageDeny);
        @(posedge clk);
        pageUserBit <= 1'b0;
        insnClass <= 2'h0;
    endtask : scnDecodeAndPages

    // short image lacks the upper word, so the flag drops
    task automatic scnShortImage;
        @(posedge clk);
        taskImage32 <= 1'b0;
        protPrivLevel <= 2'h2;
        pulse(0);
        seqCheck(1'b0);
        chk("flagsRegister", 32'h0000_0202, flagsRegister);
        chk("currentPrivilegeLevel", 2, currentPrivilegeLevel);
        chk("pageDeny", 0, pageDeny);
    endtask : scnShortImage

    task automatic scnReturnThenInit;
        @(posedge clk);
        // handler side keeps the full-width flags image
        stackFlagsImage <= 32'h0002_0002;
        pulse(1);
        settle();
        chk("flagsRegister", 32'h0002_0002, flagsRegister);
        chk("currentPrivilegeLevel", 3, currentPrivilegeLevel);
        pulse(3);
        settle();
        chk("flagsRegister", 32'h0000_0002, flagsRegister);
        chk("emulationModeFlag", 0, emulationModeFlag);
    endtask : scnReturnThenInit

    // ============================================================
    // clock, watchdog, main sequence
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run needs well under a hundred cycles
    initial
    begin
        #(40 * 3000);
        nMismatch++;
        conclude();
    end

    initial
    begin
        {resetn, initReq, taskSwitch, taskImage32, interruptReturn, flagsWrite} = '0;
        {taskFlagsImage, stackFlagsImage, flagsWriteData} = '0;
        {protPrivLevel, ioPrivLevel, insnClass, pageUserBit, pageAccess} = '0;
        segImage = 16'hFFFF;
        addrOffset = 16'hFFFF;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        settle();
        chk("flagsRegister", FLAGS_RESET, flagsRegister);
        chk("emulationModeFlag", 0, emulationModeFlag);
        scnDirectWrite();
        scnEnterByTask();
        scnDecodeAndPages();
        scnShortImage();
        scnReturnThenInit();
        conclude();
    end
endmodule : legacy_emulation_mode_entry_tb
`default_nettype wire
